// file: bench/serial_node_model.sv
`timescale 1ns/1ps
module serial_node_model #(
	parameter int BIT_CLKS = 16
) (
	input wire logic clk,
	input wire logic rx_line,
	output logic tx_line
);
	logic [7:0] got_q[$];
	initial tx_line = 1'b1;
	// Frames sampled mid-bit, so a wrong bit length shows up
	initial forever begin : rx
		logic [7:0] b;
		@(negedge rx_line);
		repeat (BIT_CLKS / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(posedge clk);
			b[i] = rx_line;
		end
		repeat (BIT_CLKS) @(posedge clk);
		if (rx_line) got_q.push_back(b);
	end
	task automatic send(input logic [7:0] v);
		logic [9:0] f;
		f = {1'b1, v, 1'b0};
		for (int i = 0; i < 10; i++) begin
			tx_line <= f[i];
			repeat (BIT_CLKS) @(posedge clk);
		end
	endtask
endmodule

// file: bench/serial_port_assertions.sv
`timescale 1ns/1ps
module serial_port_assertions
	import serial_port_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [2:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic high_speed_clock_off,
	input wire logic wakeup_request,
	input wire logic combined_irq_request_flag,
	input wire logic transmit_pin_out,
	input wire logic transmit_pin_oe_n,
	input wire logic shared_receive_pin_in,
	input wire logic shared_receive_pin_out,
	input wire logic shared_receive_pin_oe_n
);
	logic port_on;
	logic mode_on;
	logic sw;
	control_two_s ctl;
	wire tx_act = port_on && mode_on && ctl.transmitter_enable;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Shadow of the control bits, rebuilt from bus writes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			port_on <= 1'b0;
			mode_on <= 1'b0;
			sw <= 1'b0;
			ctl <= CONTROL_TWO_RESET;
		end else if (write) begin
			if (address == ADDR_CONTROL_ONE) port_on <= writedata[CONTROL_PORT_ENABLE_BIT];
			if (address == ADDR_MODE) mode_on <= writedata[0];
			if (address == ADDR_SINGLE_WIRE) sw <= writedata[0];
			if (address == ADDR_CONTROL_TWO) ctl <= writedata[7:0];
			if (address == ADDR_CONTROL_ONE && !writedata[7]) ctl[7:6] <= 2'b00;
		end
	end
	AST_TX_FLOAT: assert property (
		!tx_act [*3] |-> transmit_pin_oe_n && shared_receive_pin_oe_n) else $error("pin driven while idle");
	AST_TX_DRIVES: assert property (
		(tx_act && !sw) [*3] |-> !transmit_pin_oe_n) else $error("transmit pin not driven");
	AST_SHARED_RX_ONLY: assert property (
		!sw [*3] |-> shared_receive_pin_oe_n) else $error("shared pin driven");
	AST_SHARED_RX_WINS: assert property (
		(sw && ctl.receiver_enable) [*3] |-> shared_receive_pin_oe_n) else $error("shared pin not input");
	AST_IRQ_GATED: assert property (
		(ctl[2:0] == 3'h0) [*3] |-> !combined_irq_request_flag) else $error("ungated irq");
	AST_WAKE_QUIET: assert property (
		(!high_speed_clock_off || !ctl.pin_wakeup_enable) [*3] |-> !wakeup_request) else $error("stray wake");
	AST_WAKE_RAISE: assert property (
		$fell(shared_receive_pin_in) && high_speed_clock_off && ctl.pin_wakeup_enable
		|-> ##[1:4] wakeup_request) else $error("no wake");
	AST_SW_UPPER_ZERO: assert property (
		read && !waitrequest && address == ADDR_SINGLE_WIRE |-> readdata[31:1] == '0) else $error("upper bits set");
	AST_DATA_WIDTH: assert property (
		read && !waitrequest && address == ADDR_DATA |-> readdata[31:8] == '0) else $error("data too wide");
endmodule

// file: bench/serial_port_tb.sv
`timescale 1ns/1ps
module serial_port_tb;
	import serial_port_pkg::*;
	logic clk = 0;
	logic resetn = 0;
	logic [2:0] address = '0;
	logic read = 0;
	logic write = 0;
	logic [31:0] writedata = '0;
	logic [31:0] readdata;
	logic waitrequest;
	logic high_speed_clock_off = 0;
	logic wakeup_request;
	logic combined_irq_request_flag;
	logic transmit_pin_out;
	logic transmit_pin_oe_n;
	logic shared_receive_pin_in;
	logic shared_receive_pin_out;
	logic shared_receive_pin_oe_n;
	logic node_line;
	logic node_rx;
	logic [31:0] rd;
	logic [7:0] b;
	int failures = 0;
	int compares = 0;
	logic [7:0] exp_q[$];
	// Released lines rest high on their pull-ups
	assign shared_receive_pin_in = shared_receive_pin_oe_n ? node_line : shared_receive_pin_out;
	assign node_rx = transmit_pin_oe_n ? 1'b1 : transmit_pin_out;
	always #5 clk = ~clk;
	serial_port i_dut(.*);
	serial_node_model #(.BIT_CLKS(OVERSAMPLE_HIGH)) i_node(.clk(clk), .rx_line(node_rx), .tx_line(node_line));
	task automatic report_and_stop;
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic rw, input logic [2:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		writedata <= 32'(d);
		read <= rw;
		write <= !rw;
		// Sample waitrequest and readdata at the rising edge that ends the transfer
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest && n < 50);
		if (n >= 50) failures++;
		rd = readdata;
		read <= 0;
		write <= 0;
	endtask
	task automatic rx(input logic [7:0] v, input logic hit);
		i_node.send(v);
		repeat (8) @(posedge clk);
		chk(combined_irq_request_flag, hit);
		bus(1, ADDR_STATUS, 0);
		chk(rd[1], hit);
		if (hit) begin
			bus(1, ADDR_DATA, 0);
			chk(rd, v);
			repeat (3) @(posedge clk);
			chk(combined_irq_request_flag, 0);
		end
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		report_and_stop();
	end
	initial begin
		void'($urandom(32'h8023_f678));
		repeat (12) @(posedge clk);
		resetn <= 1;
		bus(1, ADDR_CONTROL_TWO, 0);
		chk(rd, CONTROL_TWO_RESET);
		bus(1, ADDR_SINGLE_WIRE, 0);
		chk(rd, 0);
		b = 8'($urandom);
		bus(0, ADDR_CONTROL_TWO, b & 8'h3F);
		bus(1, ADDR_CONTROL_TWO, 0);
		chk(rd, b & 8'h3F);
		b = 8'($urandom);
		bus(0, ADDR_BAUD, b);
		bus(1, ADDR_BAUD, 0);
		chk(rd, b);
		bus(0, ADDR_SINGLE_WIRE, 8'hFF);
		bus(1, ADDR_SINGLE_WIRE, 0);
		chk(rd, 1);
		bus(0, 3'h7, 8'hFF);
		bus(1, 3'h7, 0);
		chk(rd, 0);
		bus(0, ADDR_BAUD, 0);
		bus(0, ADDR_MODE, 1);
		bus(0, ADDR_CONTROL_ONE, 8'h80);
		bus(0, ADDR_CONTROL_TWO, 8'hE4);
		rx(8'hA5, 1);
		rx(8'($urandom), 1);
		bus(0, ADDR_CONTROL_TWO, 8'hF4);
		rx(8'h35, 0);
		rx(8'hB5, 1);
		bus(0, ADDR_SINGLE_WIRE, 0);
		bus(0, ADDR_CONTROL_TWO, 8'hE0);
		for (int i = 0; i < 4; i++) begin
			b = 8'($urandom);
			exp_q.push_back(b);
			bus(0, ADDR_DATA, b);
		end
		chk(transmit_pin_oe_n, 0);
		repeat (800) @(posedge clk);
		chk(i_node.got_q.size(), 4);
		foreach (exp_q[i]) chk(i_node.got_q[i], exp_q[i]);
		for (int i = 0; i < 3; i++) begin
			bus(0, ADDR_CONTROL_TWO, 8'hE0 | 8'(i));
			repeat (3) @(posedge clk);
			chk(combined_irq_request_flag, i != 0);
		end
		bus(0, ADDR_CONTROL_ONE, 0);
		repeat (3) @(posedge clk);
		chk(transmit_pin_oe_n, 1);
		bus(1, ADDR_STATUS, 0);
		chk(rd[4:2], 3'b111);
		bus(1, ADDR_CONTROL_TWO, 0);
		chk(rd, 8'h22);
		for (int i = 0; i < 2; i++) begin
			bus(0, ADDR_CONTROL_TWO, i ? 8'h08 : 8'h00);
			high_speed_clock_off <= 1;
			repeat (2) @(posedge clk);
			i_node.send(8'h00);
			chk(wakeup_request, i);
			high_speed_clock_off <= 0;
			repeat (4) @(posedge clk);
			chk(wakeup_request, 0);
		end
		report_and_stop();
	end
endmodule
bind serial_port serial_port_assertions i_chk(.*);

// file: hw/serial_baud.sv
`timescale 1ns/1ps
module serial_baud
	import serial_port_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic clear,
	input wire logic high_speed,
	input wire logic [7:0] divisor,
	output logic tick
);
	// Tick is the oversample rate; lines use 16 ticks per bit, so low speed prescales by 4
	localparam int PRESCALE = OVERSAMPLE_LOW / OVERSAMPLE_HIGH;
	logic [7:0] timer;
	logic [1:0] pre;
	logic timer_wrap;

	assign timer_wrap = (timer == 8'h00);
	assign tick = timer_wrap && (high_speed || pre == 2'(PRESCALE-1));

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			timer <= 8'h00;
			pre <= 2'h0;
		end else if (clear) begin
			timer <= divisor;
			pre <= 2'h0;
		end else if (timer_wrap) begin
			timer <= divisor;
			pre <= high_speed ? 2'h0 : pre + 2'h1;
		end else begin
			timer <= timer - 8'h01;
		end
	end
endmodule

// file: hw/serial_fifo.sv
`timescale 1ns/1ps
module serial_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] count;
	logic [AW-1:0] rd_ptr;
	logic [AW-1:0] wr_ptr;
	logic push;
	logic pop;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count <= '0;
			rd_ptr <= '0;
			wr_ptr <= '0;
		end else if (flush) begin
			count <= '0;
			rd_ptr <= '0;
			wr_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// file: hw/serial_port.sv
`timescale 1ns/1ps
module serial_port
	import serial_port_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [2:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic high_speed_clock_off,
	output logic wakeup_request,
	output logic combined_irq_request_flag,
	output logic transmit_pin_out,
	output logic transmit_pin_oe_n,
	input wire logic shared_receive_pin_in,
	output logic shared_receive_pin_out,
	output logic shared_receive_pin_oe_n
);
	localparam logic [3:0] LAST_SAMPLE = 4'hF;
	localparam logic [3:0] MID_SAMPLE = 4'h7;

	control_two_s ctl;
	logic port_enable;
	logic nine_bit_select;
	logic tx_ninth;
	logic single_wire_select;
	logic serial_mode_select;
	logic [7:0] baud_divisor;
	logic overrun_flag;
	logic tx_idle_flag;
	logic tx_empty_flag;
	logic rx_idle_flag;
	logic rx_ninth;
	logic [7:0] serial_data_buffer;
	logic rd_phase;
	logic tick;
	logic tx_active;
	logic rx_active;
	logic tx_on_shared;
	logic line_in;
	logic bus_req;
	logic data_write;
	logic data_read;
	logic tx_in_ready;
	logic tx_out_valid;
	logic tx_out_ready;
	logic [FIFO_WIDTH-1:0] tx_out_data;
	logic rx_in_valid;
	logic rx_in_ready;
	logic rx_out_valid;
	logic [FIFO_WIDTH-1:0] rx_out_data;
	logic [FIFO_WIDTH-1:0] rx_word;
	logic rx_addr_bit;
	line_state_e tx_state;
	line_state_e rx_state;
	logic [3:0] tx_sub;
	logic [3:0] rx_sub;
	logic [3:0] tx_bit;
	logic [3:0] rx_bit;
	logic [3:0] word_bits;
	logic [9:0] tx_shift;
	logic [8:0] rx_shift;
	logic rx_done;
	logic tx_busy_done;
	logic wake_prev;

	assign tx_active = ctl.transmitter_enable && serial_mode_select && port_enable;
	assign rx_active = ctl.receiver_enable && serial_mode_select && port_enable;
	assign word_bits = nine_bit_select ? 4'd9 : 4'd8;

	// Shared pin drives only in single-wire with receiver off
	assign tx_on_shared = single_wire_select && !ctl.receiver_enable;
	assign line_in = shared_receive_pin_in;

	// Pins: output enable low means driving; disabled ends float
	assign transmit_pin_out = tx_shift[0];
	assign transmit_pin_oe_n = !(tx_active && !tx_on_shared);
	assign shared_receive_pin_out = tx_shift[0];
	assign shared_receive_pin_oe_n = !(tx_active && tx_on_shared);

	// Bus: reads take one wait cycle so data come from flops
	assign bus_req = read || write;
	assign waitrequest = read && !rd_phase;
	assign data_write = write && address == ADDR_DATA;
	assign data_read = read && rd_phase && address == ADDR_DATA;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_phase <= 1'b0;
		end else begin
			rd_phase <= read && !rd_phase;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			readdata <= 32'h0000_0000;
		end else if (read && !rd_phase) begin
			unique case (address)
				ADDR_CONTROL_ONE: readdata <= {24'h00_0000, port_enable, nine_bit_select, 4'h0, rx_ninth, 1'b0};
				ADDR_CONTROL_TWO: readdata <= {24'h00_0000, ctl};
				ADDR_SINGLE_WIRE: readdata <= {31'h0000_0000, single_wire_select};
				ADDR_DATA: readdata <= {24'h00_0000, rx_out_data[7:0]};
				ADDR_BAUD: readdata <= {24'h00_0000, baud_divisor};
				ADDR_STATUS: readdata <= {26'h000_0000, combined_irq_request_flag, rx_idle_flag,
					tx_empty_flag, tx_idle_flag, rx_out_valid, overrun_flag};
				ADDR_MODE: readdata <= {31'h0000_0000, serial_mode_select};
				default: readdata <= 32'h0000_0000;
			endcase
		end
	end

	// Control registers; disabling the port clears both direction enables
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctl <= CONTROL_TWO_RESET;
			port_enable <= 1'b0;
			nine_bit_select <= 1'b0;
			tx_ninth <= 1'b0;
			single_wire_select <= 1'b0;
			serial_mode_select <= 1'b0;
			baud_divisor <= BAUD_RESET;
		end else begin
			if (write && address == ADDR_CONTROL_ONE) begin
				port_enable <= writedata[CONTROL_PORT_ENABLE_BIT];
				nine_bit_select <= writedata[CONTROL_NINE_BIT_BIT];
				tx_ninth <= writedata[CONTROL_TX_NINTH_BIT];
			end
			if (write && address == ADDR_CONTROL_TWO) begin
				ctl <= control_two_s'(writedata[7:0]);
			end
			if (write && address == ADDR_SINGLE_WIRE) begin
				single_wire_select <= writedata[0];
			end
			if (write && address == ADDR_BAUD) begin
				baud_divisor <= writedata[7:0];
			end
			if (write && address == ADDR_MODE) begin
				serial_mode_select <= writedata[0];
			end
			if (!port_enable) begin
				ctl.transmitter_enable <= 1'b0;
				ctl.receiver_enable <= 1'b0;
			end
		end
	end

	// Data register: write side is the transmit byte; storage content undefined at reset
	always_ff @(posedge clk) begin
		if (data_write) begin
			serial_data_buffer <= writedata[7:0];
		end
	end

	serial_baud u_baud (
		.clk(clk),
		.resetn(resetn),
		.clear(!port_enable),
		.high_speed(ctl.baud_speed_select),
		.divisor(baud_divisor),
		.tick(tick)
	);

	serial_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clk(clk),
		.resetn(resetn),
		.flush(!tx_active),
		.in_valid(data_write),
		.in_ready(tx_in_ready),
		.in_data({tx_ninth, writedata[7:0]}),
		.out_valid(tx_out_valid),
		.out_ready(tx_out_ready),
		.out_data(tx_out_data)
	);

	serial_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk(clk),
		.resetn(resetn),
		.flush(!rx_active),
		.in_valid(rx_in_valid),
		.in_ready(rx_in_ready),
		.in_data(rx_word),
		.out_valid(rx_out_valid),
		.out_ready(data_read),
		.out_data(rx_out_data)
	);

	// Transmitter: 16 ticks per bit, LSB first, one stop bit
	assign tx_out_ready = tx_active && tx_state == LINE_IDLE;
	assign tx_busy_done = tick && tx_state == LINE_STOP && tx_sub == LAST_SAMPLE;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_state <= LINE_IDLE;
			tx_sub <= 4'h0;
			tx_bit <= 4'h0;
			tx_shift <= 10'h3FF;
		end else if (!tx_active) begin
			tx_state <= LINE_IDLE;
			tx_sub <= 4'h0;
			tx_bit <= 4'h0;
			tx_shift <= 10'h3FF;
		end else if (tx_state == LINE_IDLE) begin
			if (tx_out_valid) begin
				tx_state <= LINE_START;
				tx_sub <= 4'h0;
				tx_bit <= 4'h0;
				// 8-bit frames put the stop level above the data, not the ninth bit
				tx_shift <= {nine_bit_select ? tx_out_data[8] : 1'b1, tx_out_data[7:0], 1'b0};
			end
		end else if (tick) begin
			tx_sub <= tx_sub + 4'h1;
			if (tx_sub == LAST_SAMPLE) begin
				tx_shift <= {1'b1, tx_shift[9:1]};
				unique case (tx_state)
					LINE_START: tx_state <= LINE_DATA;
					LINE_DATA: begin
						tx_bit <= tx_bit + 4'h1;
						if (tx_bit == word_bits - 4'h1) begin
							tx_state <= LINE_STOP;
						end
					end
					LINE_STOP: tx_state <= LINE_IDLE;
					LINE_IDLE: tx_state <= LINE_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_idle_flag <= 1'b1;
			tx_empty_flag <= 1'b1;
		end else begin
			tx_empty_flag <= !tx_active || tx_in_ready;
			tx_idle_flag <= !tx_active || (tx_state == LINE_IDLE && !tx_out_valid) || tx_busy_done;
		end
	end

	// Receiver: midpoint sampling of start and data bits on the shared pin; stop checked 8 ticks after the last data sample
	assign rx_done = tick && rx_state == LINE_STOP && rx_sub == MID_SAMPLE;
	assign rx_word = nine_bit_select ? rx_shift : {1'b0, rx_shift[8:1]};
	assign rx_addr_bit = nine_bit_select ? rx_shift[8] : rx_shift[8];
	// Address-detect drops words with clear address bit
	assign rx_in_valid = rx_done && line_in && (!ctl.address_detect_enable || rx_addr_bit);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_state <= LINE_IDLE;
			rx_sub <= 4'h0;
			rx_bit <= 4'h0;
			rx_shift <= 9'h000;
		end else if (!rx_active) begin
			rx_state <= LINE_IDLE;
			rx_sub <= 4'h0;
			rx_bit <= 4'h0;
		end else if (tick) begin
			rx_sub <= rx_sub + 4'h1;
			unique case (rx_state)
				LINE_IDLE: begin
					rx_sub <= 4'h0;
					if (!line_in) begin
						rx_state <= LINE_START;
					end
				end
				LINE_START: if (rx_sub == MID_SAMPLE) begin
					rx_sub <= 4'h0;
					rx_bit <= 4'h0;
					rx_state <= line_in ? LINE_IDLE : LINE_DATA;
				end
				LINE_DATA: if (rx_sub == LAST_SAMPLE) begin
					rx_shift <= {line_in, rx_shift[8:1]};
					rx_bit <= rx_bit + 4'h1;
					if (rx_bit == word_bits - 4'h1) begin
						rx_state <= LINE_STOP;
					end
				end
				LINE_STOP: if (rx_sub == MID_SAMPLE) begin
					rx_state <= LINE_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_ninth <= 1'b0;
			overrun_flag <= 1'b0;
			rx_idle_flag <= 1'b1;
		end else begin
			rx_idle_flag <= !rx_active || rx_state == LINE_IDLE;
			if (data_read) begin
				rx_ninth <= rx_out_data[8];
			end
			if (!port_enable) begin
				overrun_flag <= 1'b0;
			end else if (rx_in_valid && !rx_in_ready) begin
				overrun_flag <= 1'b1;
			end else if (read && rd_phase && address == ADDR_STATUS) begin
				overrun_flag <= 1'b0;
			end
		end
	end

	// Combined request follows the enabled sources
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			combined_irq_request_flag <= 1'b0;
		end else begin
			combined_irq_request_flag <= (ctl.receive_irq_enable && (overrun_flag || rx_out_valid))
				|| (ctl.tx_idle_irq_enable && tx_idle_flag && port_enable)
				|| (ctl.tx_empty_irq_enable && tx_empty_flag && port_enable);
		end
	end

	// Wakeup: raw pin edge, only while the fast clock is off
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wake_prev <= 1'b1;
			wakeup_request <= 1'b0;
		end else begin
			wake_prev <= line_in;
			if (!high_speed_clock_off || !ctl.pin_wakeup_enable) begin
				wakeup_request <= 1'b0;
			end else if (wake_prev && !line_in) begin
				wakeup_request <= 1'b1;
			end
		end
	end
endmodule

// file: include/serial_port_pkg.sv
package serial_port_pkg;
	localparam logic [2:0] ADDR_CONTROL_ONE = 3'h0;
	localparam logic [2:0] ADDR_CONTROL_TWO = 3'h1;
	localparam logic [2:0] ADDR_SINGLE_WIRE = 3'h2;
	localparam logic [2:0] ADDR_DATA = 3'h3;
	localparam logic [2:0] ADDR_BAUD = 3'h4;
	localparam logic [2:0] ADDR_STATUS = 3'h5;
	localparam logic [2:0] ADDR_MODE = 3'h6;
	localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;
	localparam logic [7:0] BAUD_RESET = 8'h00;
	localparam int CONTROL_PORT_ENABLE_BIT = 7;
	localparam int CONTROL_NINE_BIT_BIT = 6;
	localparam int CONTROL_TX_NINTH_BIT = 0;
	localparam int OVERSAMPLE_HIGH = 16;
	localparam int OVERSAMPLE_LOW = 64;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_WIDTH = 9;

	typedef struct packed {
		logic transmitter_enable;
		logic receiver_enable;
		logic baud_speed_select;
		logic address_detect_enable;
		logic pin_wakeup_enable;
		logic receive_irq_enable;
		logic tx_idle_irq_enable;
		logic tx_empty_irq_enable;
	} control_two_s;

	typedef enum logic [1:0] {
		LINE_IDLE,
		LINE_START,
		LINE_DATA,
		LINE_STOP
	} line_state_e;
endpackage
